/* File: rcwd_pkg.sv */
// constants and types for the reset cause and watchdog block
`default_nettype none
package rcwd_pkg;
    // clock and documented times
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS     = 1000000;
    localparam int T_POR_NS      = 10000;
    localparam int T_FSCM_NS     = 100000;
    localparam int T_PWRT_A_MS   = 4;
    localparam int T_PWRT_B_MS   = 16;
    localparam int T_PWRT_C_MS   = 64;
    // least times round up
    localparam int POR_CYC  = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FSCM_CYC = (T_FSCM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // register map
    localparam logic [7:0] ADDR_CAUSE  = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [1:0] AXI_OKAY    = 2'h0;
    localparam logic [1:0] AXI_SLVERR  = 2'h2;
    // reset_cause_reg bit positions
    localparam int BIT_TRAP  = 15;
    localparam int BIT_ILL   = 14;
    localparam int BIT_EXT_PIN_RESET_FLAG  = 7;
    localparam int BIT_SWR   = 6;
    localparam int BIT_SWDT  = 5;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG  = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_IDLE  = 2;
    localparam int BIT_BOR   = 1;
    localparam int BIT_POR   = 0;
    localparam logic [15:0] CAUSE_WMASK   = 16'hc0ff;
    localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
    // program counter targets
    localparam logic [23:0] RESET_VEC = 24'h000000;
    localparam logic [23:0] PC_STEP   = 24'h000002;
    // fuse decoding
    localparam logic [1:0] OSC_GRP_PRIMARY = 2'h3;
    localparam int         PRIM_PLL_BIT    = 2;
    localparam int         PRIM_XTAL_BIT   = 3;
    localparam logic [1:0] BAND_TOP        = 2'h2;
    localparam logic [1:0] PWRT_OFF        = 2'h0;
    localparam logic [1:0] PWRT_A          = 2'h1;
    localparam logic [1:0] PWRT_B          = 2'h2;

    typedef enum logic [1:0] {
        SEQ_RUN     = 2'b00,
        SEQ_DELAY   = 2'b01,
        SEQ_CLKWAIT = 2'b11
    } rcwd_seq_t;

    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_IDLE  = 2'b01,
        PM_SLEEP = 2'b11
    } rcwd_pm_t;

    typedef struct packed {
        logic [1:0] osc_group_fuse;
        logic [3:0] primary_osc_fuse;
        logic [1:0] pwrt_sel;
        logic [1:0] bor_band;
        logic       bor_en;
        logic       watchdog_enable_fuse;
    } rcwd_fuse_t;
endpackage
`default_nettype wire

/* File: rcwd_top.sv */
// reset sequencer, reset-cause register and watchdog with AXI4-Lite access
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
// Operation
// - three brown-out trip bands select threshold
// - brown-out pulses reset, reloads clock source
// - oscillator start-up wait and PLL lock gate
// - power-on plus power-up delays before release
// - zero power-up with crystal adds monitor delay
// - brown-out and power-on set their cause flags
// - brown-out detector works in low-power states
// - software reads and writes all cause flags
// - pin reset while running updates flags
// - software reset instruction updates flags
// - pin reset in sleep sets sleep flag
// - pin reset in idle sets idle flag
// - watchdog overflow outside sleep resets device
// - watchdog overflow in sleep wakes at next
// - interrupt wake from sleep loads its vector
// - watchdog runs free on its own tick
// - watchdog fuse set forces watchdog on
// - soft enable bit controls watchdog when fuse clear
// - power save only via its instruction
// - trap lockup sets its flag, restarts
// - illegal operation sets its flag, restarts
module rcwd_top
    import rcwd_pkg::*;
#(
    parameter int DW        = 23,
    parameter int PWRT_A_CY = T_PWRT_A_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int PWRT_B_CY = T_PWRT_B_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int PWRT_C_CY = T_PWRT_C_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int OST_CY    = 1024,
    parameter int LPRC_DIV  = 32,
    parameter int WDT_W     = 16
)(
    // clock and power-on reset
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    // fuses and analog comparators
    input  wire rcwd_fuse_t  FUSES,
    input  wire logic [2:0]  SUPPLY_BELOW,
    input  wire logic        PLL_LOCK,
    // core events
    input  wire logic        MASTER_CLEAR_PIN_PIN_N,
    input  wire logic        SOFT_RESET_INSTR,
    input  wire logic        TRAP_LOCKUP,
    input  wire logic        ILLEGAL_OP,
    input  wire logic        WDT_CLEAR_INSTR,
    input  wire logic        POWER_SAVE_INSTR,
    input  wire logic        POWER_SAVE_IDLE,
    input  wire logic        INT_WAKE,
    input  wire logic [23:0] INT_VECTOR,
    input  wire logic [23:0] CUR_PC,
    // core control
    output logic             SYS_RESET,
    output logic             CLK_HOLD,
    output logic             PC_LOAD,
    output logic [23:0]      PC_TARGET,
    output logic [1:0]       CLK_GROUP,
    output logic [3:0]       CLK_PRIMARY,
    output logic             SLEEP_MODE,
    output logic             IDLE_MODE,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    rcwd_seq_t         seq_q;
    rcwd_pm_t          pm_q;
    logic [15:0]       cause_q;
    logic [15:0]       cause_d;
    logic [DW-1:0]     dly_q;
    logic [DW-1:0]     ost_q;
    logic [WDT_W-1:0]  wdt_q;
    logic [7:0]        div_q;
    logic              tick_q;
    logic              por_pend_q;
    logic              master_clear_pin_prev_q;
    logic              pll_used_q;
    logic              wr_fire;
    logic              ev_por, ev_bor, ev_master_clear_pin, ev_sw, ev_wrst;
    logic              ev_wwake, ev_iwake, ev_trap, ev_ill;
    logic              ev_warm, bor_trip, wdt_en, wdt_ovf, live;
    logic [DW-1:0]     full_dly;

    ////////////////////////////////////////////////////////////////////
    // fuse decode

    function automatic logic [DW-1:0] pwrt_cyc(input logic [1:0] s);
        case (s)
            PWRT_OFF: pwrt_cyc = '0;
            PWRT_A:   pwrt_cyc = DW'(PWRT_A_CY);
            PWRT_B:   pwrt_cyc = DW'(PWRT_B_CY);
            default:  pwrt_cyc = DW'(PWRT_C_CY);
        endcase
    endfunction

    function automatic logic prim_bit(input rcwd_fuse_t f,
                                      input int b);
        prim_bit = (f.osc_group_fuse == OSC_GRP_PRIMARY) &&
                   f.primary_osc_fuse[b];
    endfunction

    always_comb
    begin
        full_dly = DW'(POR_CYC) + pwrt_cyc(FUSES.pwrt_sel);
        if (FUSES.pwrt_sel == PWRT_OFF && prim_bit(FUSES, PRIM_XTAL_BIT))
            full_dly = DW'(POR_CYC + FSCM_CYC);
    end

    ////////////////////////////////////////////////////////////////////
    // event detection, one reset per cycle; an interrupt wake can share its cycle with a trap, illegal op or soft reset

    // unused band code falls back to the highest band
    assign bor_trip = FUSES.bor_en && SUPPLY_BELOW[
        (FUSES.bor_band > BAND_TOP) ? BAND_TOP : FUSES.bor_band];
    assign wdt_en  = FUSES.watchdog_enable_fuse || cause_q[BIT_SWDT];
    assign wdt_ovf = wdt_en && tick_q && (&wdt_q);
    assign live    = (seq_q == SEQ_RUN) && !ev_por && !ev_bor;
    assign ev_por  = por_pend_q;
    assign ev_bor  = bor_trip && !por_pend_q;
    assign ev_master_clear_pin = live && master_clear_pin_prev_q && !MASTER_CLEAR_PIN_PIN_N;
    assign ev_wrst = live && !ev_master_clear_pin && wdt_ovf && pm_q != PM_SLEEP;
    assign ev_wwake = live && !ev_master_clear_pin && wdt_ovf && pm_q == PM_SLEEP;
    assign ev_trap = live && !ev_master_clear_pin && !wdt_ovf && TRAP_LOCKUP;
    assign ev_ill  = live && !ev_master_clear_pin && !wdt_ovf && !TRAP_LOCKUP &&
                     ILLEGAL_OP;
    assign ev_sw   = live && !ev_master_clear_pin && !wdt_ovf && !TRAP_LOCKUP &&
                     !ILLEGAL_OP && SOFT_RESET_INSTR;
    assign ev_iwake = live && !ev_master_clear_pin && !wdt_ovf && INT_WAKE &&
                      pm_q != PM_RUN;
    assign ev_warm = ev_master_clear_pin | ev_wrst | ev_trap | ev_ill | ev_sw;

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            por_pend_q  <= 1'b1;
            master_clear_pin_prev_q <= 1'b1;
        end
        else
        begin
            por_pend_q  <= 1'b0;
            master_clear_pin_prev_q <= MASTER_CLEAR_PIN_PIN_N;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset-cause register: software write first, then the event on top

    always_comb
    begin
        cause_d = cause_q;
        if (wr_fire && S_AXI_AWADDR == ADDR_CAUSE)
            cause_d = (cause_q & ~(CAUSE_WMASK & {{8{S_AXI_WSTRB[1]}},
                      {8{S_AXI_WSTRB[0]}}})) | (S_AXI_WDATA[15:0] &
                      CAUSE_WMASK & {{8{S_AXI_WSTRB[1]}},
                      {8{S_AXI_WSTRB[0]}}});
        if (ev_por)
            cause_d = CAUSE_POR_VAL;
        else if (ev_bor)
        begin
            cause_d[BIT_BOR] = 1'b1;
            cause_d[BIT_POR] = 1'b0;
        end
        else if (ev_master_clear_pin)
        begin
            cause_d[BIT_EXT_PIN_RESET_FLAG]  = 1'b1;
            cause_d[BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
            cause_d[BIT_SLEEP] = (pm_q == PM_SLEEP);
            cause_d[BIT_IDLE]  = (pm_q == PM_IDLE);
            if (pm_q == PM_RUN)
                cause_d[BIT_SWR] = 1'b0;
        end
        else if (ev_wrst || ev_sw)
        begin
            cause_d[BIT_WATCHDOG_TIMEOUT_FLAG]  = ev_wrst;
            cause_d[BIT_SWR]   = ev_sw;
            cause_d[BIT_EXT_PIN_RESET_FLAG]  = 1'b0;
            cause_d[BIT_SLEEP] = 1'b0;
            cause_d[BIT_IDLE]  = 1'b0;
        end
        else if (ev_trap)
            cause_d[BIT_TRAP] = 1'b1;
        else if (ev_ill)
            cause_d[BIT_ILL] = 1'b1;
        else if (ev_wwake)
        begin
            cause_d[BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
            cause_d[BIT_SLEEP] = 1'b1;
        end
        else if (ev_iwake)
        begin
            cause_d[BIT_SLEEP] = cause_d[BIT_SLEEP] | (pm_q == PM_SLEEP);
            cause_d[BIT_IDLE]  = cause_d[BIT_IDLE] | (pm_q == PM_IDLE);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            cause_q <= CAUSE_POR_VAL;
        else
            cause_q <= cause_d;
    end

    ////////////////////////////////////////////////////////////////////
    // reset sequencer

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            seq_q      <= SEQ_DELAY;
            dly_q      <= '0;
            ost_q      <= '0;
            pll_used_q <= 1'b0;
            SYS_RESET  <= 1'b1;
            CLK_HOLD   <= 1'b1;
            CLK_GROUP  <= '0;
            CLK_PRIMARY <= '0;
        end
        else if (ev_por || ev_bor)
        begin
            seq_q       <= SEQ_DELAY;
            SYS_RESET   <= 1'b1;
            dly_q       <= full_dly - DW'(1);
            CLK_GROUP   <= FUSES.osc_group_fuse;
            CLK_PRIMARY <= FUSES.primary_osc_fuse;
            ost_q       <= (FUSES.osc_group_fuse == OSC_GRP_PRIMARY) ?
                           DW'(OST_CY) : '0;
            pll_used_q  <= prim_bit(FUSES, PRIM_PLL_BIT);
            CLK_HOLD    <= 1'b1;
        end
        else if (ev_warm)
        begin
            seq_q     <= SEQ_DELAY;
            SYS_RESET <= 1'b1;
            dly_q     <= DW'(POR_CYC - 1);
        end
        else
        begin
            if (ost_q != '0)
                ost_q <= ost_q - DW'(1);
            CLK_HOLD <= (ost_q > DW'(1)) ||
                        (pll_used_q && !PLL_LOCK);
            case (seq_q)
                SEQ_DELAY:
                begin
                    if (dly_q != '0)
                        dly_q <= dly_q - DW'(1);
                    else if (MASTER_CLEAR_PIN_PIN_N)
                        seq_q <= SEQ_CLKWAIT;
                end
                SEQ_CLKWAIT:
                begin
                    if (ost_q == '0 && (!pll_used_q || PLL_LOCK))
                    begin
                        seq_q     <= SEQ_RUN;
                        SYS_RESET <= 1'b0;
                    end
                end
                SEQ_RUN:
                    SYS_RESET <= 1'b0;
                default:
                    seq_q <= SEQ_DELAY;
            endcase
        end
    end

    // program counter target
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PC_LOAD   <= 1'b0;
            PC_TARGET <= RESET_VEC;
        end
        else
        begin
            PC_LOAD <= 1'b0;
            if (seq_q == SEQ_CLKWAIT && ost_q == '0 && !ev_por && !ev_bor
                && !ev_warm && (!pll_used_q || PLL_LOCK))
            begin
                PC_LOAD   <= 1'b1;
                PC_TARGET <= RESET_VEC;
            end
            else if (ev_wwake)
            begin
                PC_LOAD   <= 1'b1;
                PC_TARGET <= CUR_PC + PC_STEP;
            end
            else if (ev_iwake)
            begin
                PC_LOAD   <= 1'b1;
                PC_TARGET <= INT_VECTOR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-saving state

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pm_q       <= PM_RUN;
            SLEEP_MODE <= 1'b0;
            IDLE_MODE  <= 1'b0;
        end
        else if (ev_por || ev_bor || ev_warm || ev_wwake || ev_iwake)
        begin
            pm_q       <= PM_RUN;
            SLEEP_MODE <= 1'b0;
            IDLE_MODE  <= 1'b0;
        end
        else if (live && pm_q == PM_RUN && POWER_SAVE_INSTR)
        begin
            pm_q       <= POWER_SAVE_IDLE ? PM_IDLE : PM_SLEEP;
            SLEEP_MODE <= !POWER_SAVE_IDLE;
            IDLE_MODE  <= POWER_SAVE_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog: own tick, not gated by sleep or the system clock hold

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == 8'(LPRC_DIV - 1));
            div_q  <= (div_q == 8'(LPRC_DIV - 1)) ? '0 : div_q + 8'h01;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            wdt_q <= '0;
        else if (!wdt_en || WDT_CLEAR_INSTR || ev_por || ev_bor ||
                 ev_warm || ev_wwake)
            wdt_q <= '0;
        else if (tick_q)
            wdt_q <= wdt_q + WDT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: write readies pulse one cycle after both valids, read ready one cycle after ARVALID

    assign wr_fire = S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WVALID;

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= AXI_OKAY;
        end
        else
        begin
            S_AXI_AWREADY <= S_AXI_AWVALID && S_AXI_WVALID &&
                             !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY  <= S_AXI_AWVALID && S_AXI_WVALID &&
                             !S_AXI_AWREADY && !S_AXI_BVALID;
            if (wr_fire)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (S_AXI_AWADDR == ADDR_CAUSE ||
                                 S_AXI_AWADDR == ADDR_STATUS) ?
                                AXI_OKAY : AXI_SLVERR;
            end
            else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= AXI_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY &&
                             !S_AXI_RVALID;
            if (S_AXI_ARREADY && S_AXI_ARVALID)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= AXI_OKAY;
                case (S_AXI_ARADDR)
                    ADDR_CAUSE:  S_AXI_RDATA <= {16'h0000, cause_q};
                    ADDR_STATUS: S_AXI_RDATA <= {20'h00000, wdt_en,
                                     CLK_HOLD, seq_q, pm_q,
                                     CLK_GROUP, CLK_PRIMARY};
                    default:
                    begin
                        S_AXI_RDATA <= '0;
                        S_AXI_RRESP <= AXI_SLVERR;
                    end
                endcase
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    bor_flags_a: assert property (ev_bor |=> cause_q[BIT_BOR] &&
        !cause_q[BIT_POR]) else $error("brown-out flags wrong");
    bor_hold_a: assert property (ev_bor |=> SYS_RESET[*8])
        else $error("reset released too early");
    master_clear_pin_run_a: assert property (ev_master_clear_pin && pm_q == PM_RUN |=>
        cause_q[BIT_EXT_PIN_RESET_FLAG] && !cause_q[BIT_SWR] && SYS_RESET)
        else $error("pin reset flags wrong");
    master_clear_pin_sleep_a: assert property (ev_master_clear_pin && pm_q == PM_SLEEP |=>
        cause_q[BIT_SLEEP] && !cause_q[BIT_WATCHDOG_TIMEOUT_FLAG] && !SLEEP_MODE)
        else $error("pin reset in sleep wrong");
    soft_rst_a: assert property (ev_sw |=> cause_q[BIT_SWR] &&
        !cause_q[BIT_EXT_PIN_RESET_FLAG] && SYS_RESET) else $error("soft reset wrong");
    wdt_wake_a: assert property (ev_wwake |=> PC_LOAD &&
        PC_TARGET == $past(CUR_PC) + PC_STEP && !SYS_RESET)
        else $error("watchdog wake wrong");
    wdt_rst_a: assert property (ev_wrst |=> cause_q[BIT_WATCHDOG_TIMEOUT_FLAG] &&
        !cause_q[BIT_IDLE] && SYS_RESET) else $error("watchdog reset");
    int_wake_a: assert property (ev_iwake && pm_q == PM_SLEEP |=>
        PC_TARGET == $past(INT_VECTOR) && cause_q[BIT_SLEEP])
        else $error("interrupt wake wrong");
    trap_flag_a: assert property (ev_trap |=> cause_q[BIT_TRAP])
        else $error("trap flag not set");
    sleep_entry_a: assert property ($rose(SLEEP_MODE) |->
        $past(POWER_SAVE_INSTR)) else $error("sleep without instr");
    release_a: assert property ($fell(SYS_RESET) |->
        $past(ost_q) == '0 && (!pll_used_q || $past(PLL_LOCK)))
        else $error("clock not ready at release");
    fuse_on_a: assert property (FUSES.watchdog_enable_fuse && tick_q &&
        !WDT_CLEAR_INSTR && !ev_por && !ev_bor && !ev_warm && !ev_wwake
        |=> wdt_q == $past(wdt_q) + WDT_W'(1))
        else $error("fuse did not force watchdog");

    cover property (ev_bor && pm_q == PM_SLEEP);
    cover property (ev_wwake);
    cover property (ev_master_clear_pin && pm_q == PM_IDLE);

endmodule
`default_nettype wire

/* File: rcwd_tb.sv */
// self-checking bench for the reset cause and watchdog block
`default_nettype none
module testbench import rcwd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [1:0]  md;
        logic [2:0]  ev;
        logic [9:0]  fz;
        logic [2:0]  sup;
        logic [15:0] pre;
        logic [15:0] exp;
        logic [15:0] dmin;
    } rcwd_row_t;
    logic        clk, rstn, master_clear_pin_n, srst, trap, ill, wclr, psi, psidl, iw;
    logic        sysr, ckh, pcl, slm, idm, awv, awr, wv, wr, bv, br;
    logic        arv, arr, rv, rr, pll;
    logic [2:0]  sup;
    logic [23:0] ivec, cpc, pct;
    logic [1:0]  cgrp, bresp, rresp, rs;
    logic [3:0]  cprim, ws;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    rcwd_fuse_t  fz;
    rcwd_row_t   r;
    int          miscompares, n_checks, n;
    // mode, event, fuses, supply, preset, expected flags, least hold
    rcwd_row_t   rows [9] = '{
        '{2'h0, 3'h0, 10'h000, 3'h0, 16'hc0df, 16'hc083, 16'd400},
        '{2'h0, 3'h1, 10'h000, 3'h0, 16'hc0df, 16'hc043, 16'd400},
        '{2'h0, 3'h2, 10'h000, 3'h0, 16'h40df, 16'hc0df, 16'd400},
        '{2'h0, 3'h3, 10'h000, 3'h0, 16'h80df, 16'hc0df, 16'd400},
        '{2'h1, 3'h0, 10'h000, 3'h0, 16'h0040, 16'h00c4, 16'd400},
        '{2'h3, 3'h0, 10'h000, 3'h0, 16'h0040, 16'h00c8, 16'd400},
        '{2'h0, 3'h5, 10'h000, 3'h0, 16'h00cc, 16'h0010, 16'd400},
        '{2'h3, 3'h4, 10'h380, 3'h1, 16'hc0dd, 16'hc0de, 16'd4400},
        '{2'h0, 3'h4, 10'h006, 3'h4, 16'hc0dd, 16'hc0de, 16'd450}};

    // short power-up counts keep the run brief
    rcwd_top #(.PWRT_A_CY(50), .PWRT_B_CY(60), .PWRT_C_CY(70), .OST_CY(16),
        .WDT_W(4)) u_rcwd_top (
        .CORE_CLK(clk), .RSTN(rstn), .FUSES(fz), .SUPPLY_BELOW(sup),
        .PLL_LOCK(pll), .MASTER_CLEAR_PIN_PIN_N(master_clear_pin_n), .SOFT_RESET_INSTR(srst),
        .TRAP_LOCKUP(trap), .ILLEGAL_OP(ill), .WDT_CLEAR_INSTR(wclr),
        .POWER_SAVE_INSTR(psi), .POWER_SAVE_IDLE(psidl), .INT_WAKE(iw),
        .INT_VECTOR(ivec), .CUR_PC(cpc), .SYS_RESET(sysr), .CLK_HOLD(ckh),
        .PC_LOAD(pcl), .PC_TARGET(pct), .CLK_GROUP(cgrp),
        .CLK_PRIMARY(cprim), .SLEEP_MODE(slm), .IDLE_MODE(idm),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge clk); while (bv !== 1'b1);
        rs = bresp;
        br <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        chk(rd, e);
        rr <= 1'b0;
    endtask
    // release of internal reset, counting cycles held
    task automatic rel();
        n = 0;
        while (sysr === 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic ps(input logic idle);
        @(posedge clk);
        psi <= 1'b1;
        psidl <= idle;
        @(posedge clk);
        psi <= 1'b0;
    endtask
    task automatic wpc(input logic [23:0] e);
        n = 0;
        do @(posedge clk); while (pcl !== 1'b1 && n++ < 1000);
        chk(pct, e);
    endtask
////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial
    begin
        {rstn, srst, trap, ill, wclr, psi, psidl, iw, awv, wv, br} = '0;
        {arv, rr, sup, awa, ara, wd, fz} = '0;
        {master_clear_pin_n, pll, ws} = 6'h3f;
        fz.bor_en = 1'b1;
        ivec = 24'h000100;
        cpc = 24'h000200;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rel();
        chk(pcl, 1'b1);
        chk(pct, RESET_VEC);
        rdc(ADDR_CAUSE, 32'h0003);
        // only the upper byte lane is enabled
        ws <= 4'h2;
        axw(ADDR_CAUSE, 32'hffff);
        ws <= 4'hf;
        rdc(ADDR_CAUSE, 32'hc003);
        rdc(8'h08, 32'h0);
        chk(rresp, AXI_SLVERR);
        axw(ADDR_STATUS, 32'hffff);
        chk(rs, AXI_OKAY);
        axw(8'h0c, 32'h0);
        chk(rs, AXI_SLVERR);
        foreach (rows[i])
        begin
            r = rows[i];
            {fz.osc_group_fuse, fz.primary_osc_fuse, fz.pwrt_sel,
                fz.bor_band} <= r.fz;
            axw(ADDR_CAUSE, {16'h0, r.pre});
            if (r.md != 2'h0)
                ps(r.md == 2'h1);
            @(posedge clk);
            chk({slm, idm}, {r.md == 2'h3, r.md == 2'h1});
            case (r.ev)
                3'h0: master_clear_pin_n <= 1'b0;
                3'h1: srst <= 1'b1;
                3'h2: trap <= 1'b1;
                3'h3: ill <= 1'b1;
                3'h4: sup <= r.sup;
                default: fz.watchdog_enable_fuse <= 1'b1;
            endcase
            n = 0;
            do @(posedge clk); while (sysr !== 1'b1 && n++ < 1000);
            {srst, trap, ill, sup, fz.watchdog_enable_fuse} <= '0;
            master_clear_pin_n <= 1'b1;
            rel();
            chk(32'(n >= r.dmin), 32'h1);
            chk(pcl, 1'b1);
            chk(pct, RESET_VEC);
            rdc(ADDR_CAUSE, r.exp);
            if (r.ev == 3'h4)
                chk(cgrp, r.fz[9:8]);
            $display("event row %0d done", i);
        end
        // pll not locked: reset must hold past every delay
        {fz.osc_group_fuse, fz.primary_osc_fuse} <= 6'h34;
        {pll, sup} <= 4'h4;
        repeat (2) @(posedge clk);
        sup <= 3'h0;
        repeat (1000) @(posedge clk);
        chk({sysr, ckh}, 2'h3);
        pll <= 1'b1;
        rel();
        chk(32'(n <= 2), 32'h1);
        chk(ckh, 1'b0);
        rdc(ADDR_STATUS, 32'h0034);
        $display("pll hold test done");
        axw(ADDR_CAUSE, 32'h0020);
        ps(1'b0);
        wpc(cpc + PC_STEP);
        rdc(ADDR_CAUSE, 32'h0038);
        axw(ADDR_CAUSE, 32'h0);
        ps(1'b0);
        @(posedge clk);
        chk(slm, 1'b1);
        iw <= 1'b1;
        @(posedge clk);
        iw <= 1'b0;
        wpc(ivec);
        rdc(ADDR_CAUSE, 32'h0008);
        $display("wake tests done");
        axw(ADDR_CAUSE, 32'h0020);
        repeat (20)
        begin
            repeat (100) @(posedge clk);
            wclr <= 1'b1;
            @(posedge clk);
            wclr <= 1'b0;
        end
        chk(sysr, 1'b0);
        rdc(ADDR_CAUSE, 32'h0020);
        $display("watchdog clear test done");
        // second power-on in mid-run clears the soft enable too
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rel();
        chk(pcl, 1'b1);
        rdc(ADDR_CAUSE, 32'h0003);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
